// *** logic/tsr_top.sv ***
// TDM time slot router: slot assigner, routing RAMs, dedicated pin muxing
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tsr_top (
   // Clock and reset
   input  wire logic                        i_clock,
   input  wire logic                        i_resetn,
   // Register port
   input  wire logic [tsr_pkg::AW-1:0]      i_addr,
   input  wire logic [tsr_pkg::DW-1:0]      i_wdata,
   input  wire logic                        i_wr_stb,
   input  wire logic                        i_rd_stb,
   output logic      [tsr_pkg::DW-1:0]      o_rdata,
   // TDM links
   input  wire logic [tsr_pkg::NLINK-1:0]   i_tdm_rclk,
   input  wire logic [tsr_pkg::NLINK-1:0]   i_tdm_rsync,
   input  wire logic [tsr_pkg::NLINK-1:0]   i_tdm_rxd,
   input  wire logic [tsr_pkg::NLINK-1:0]   i_tdm_tclk,
   input  wire logic [tsr_pkg::NLINK-1:0]   i_tdm_tsync,
   output logic      [tsr_pkg::NLINK-1:0]   o_tdm_txd,
   output logic      [tsr_pkg::NLINK-1:0]   o_tdm_txd_oe,
   output logic      [tsr_pkg::NLINK-1:0]   o_tdm_clk2x,
   output logic      [tsr_pkg::NSTB-1:0]    o_strobe,
   // Dedicated pins
   input  wire logic [tsr_pkg::NEXT-1:0]    i_ext_clk,
   input  wire logic [tsr_pkg::NBAUD-1:0]   i_baud_gen,
   input  wire logic [tsr_pkg::NCH-1:0]     i_dp_rxd,
   output logic      [tsr_pkg::NCH-1:0]     o_dp_txd,
   // Serial channel side
   input  wire logic [tsr_pkg::NCH-1:0]     i_ch_txd,
   output logic      [tsr_pkg::NCH-1:0]     o_ch_rx_stb,
   output logic      [tsr_pkg::NCH-1:0]     o_ch_rx_bit,
   output logic      [tsr_pkg::NCH-1:0]     o_ch_tx_stb,
   output logic      [tsr_pkg::NCH-1:0]     o_ch_clk
);
   import tsr_pkg::*;

   logic [1:0]         rst_q;
   logic               rstn;
   logic [NPIN-1:0]    meta_q;
   logic [NPIN-1:0]    pin_q;
   logic [DW-1:0]      cfg_q;
   logic [NCH-1:0]     chen_q;
   logic [NLINK-1:0]   swap_q;
   logic [NLINK-1:0]   act_q;
   logic [NLINK-1:0]   act_d;
   logic [NCH*CKW-1:0] cksel_q;
   logic [NSTB*SSW-1:0] stbsel_q;
   logic [DW-1:0]      txram [RAMN];
   logic [DW-1:0]      rxram [RAMN];
   logic [DW-1:0]      rd_d;
   logic [IW-1:0]      pm1_w;
   logic [1:0]         sh_w;
   logic               wr_tx, wr_rx, wr_cfg, wr_chen, wr_ck0, wr_ck1, wr_stbsel;

   // Per-engine state: engine e serves link e/2, transmit when e is odd
   tsr_state_e         st_q   [NENG];
   logic [IW-1:0]      idx_q  [NENG];
   logic [CNTW-1:0]    cnt_q  [NENG];
   logic [FW-1:0]      fb_q   [NENG];
   logic [1:0]         dly_q  [NENG];
   logic [NSTB-1:0]    stb_q  [NENG];
   logic               ckp_q  [NENG];
   logic               syp_q  [NENG];
   logic               ph_q   [NENG];
   logic               edge_w [NENG];
   logic               tick_w [NENG];
   logic               sdet_w [NENG];
   logic               lon_w  [NENG];
   logic               rb_w   [NENG];
   logic               run_w  [NENG];
   logic [DW-1:0]      ent_w  [NENG];
   logic [IW-1:0]      base_w [NENG];
   logic [IW-1:0]      base_n [NENG];
   logic [NCH-1:0]     hit_w  [NENG];

   // Reset release through two flops
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rstn = rst_q[1];

   // All pin inputs except the baud generators share one two-flop synchroniser so clock and data keep alignment
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         pin_q  <= '0;
      end else begin
         meta_q <= {i_dp_rxd, i_ext_clk, i_tdm_rxd, i_tdm_tsync,
                    i_tdm_tclk, i_tdm_rsync, i_tdm_rclk};
         pin_q  <= meta_q;
      end
   end

   // Register decode
   assign wr_tx     = i_wr_stb && (i_addr[AW-1 -: 2] == RAM_SEL_TX);
   assign wr_rx     = i_wr_stb && (i_addr[AW-1 -: 2] == RAM_SEL_RX);
   assign wr_cfg    = i_wr_stb && (i_addr == OFF_CFG);
   assign wr_chen   = i_wr_stb && (i_addr == OFF_CHEN);
   assign wr_ck0    = i_wr_stb && (i_addr == OFF_CKSEL);
   assign wr_ck1    = i_wr_stb && (i_addr == OFF_CKSEL_HI);
   assign wr_stbsel = i_wr_stb && (i_addr == OFF_STBSEL);

   // Routing RAMs have no reset; software fills them first
   always_ff @(posedge i_clock) begin
      if (wr_tx) txram[i_addr[IW-1:0]] <= i_wdata;
      if (wr_rx) rxram[i_addr[IW-1:0]] <= i_wdata;
   end

   // Control registers
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         cfg_q    <= REG_RST;
         chen_q   <= '0;
         cksel_q  <= '0;
         stbsel_q <= '0;
      end else begin
         if (wr_cfg) cfg_q <= i_wdata;
         if (wr_chen) chen_q <= i_wdata[NCH-1:0];
         if (wr_ck0) cksel_q[CKSEL_LO_W-1:0] <= i_wdata;
         if (wr_ck1) cksel_q[NCH*CKW-1:CKSEL_LO_W] <= i_wdata[NCH*CKW-CKSEL_LO_W-1:0];
         if (wr_stbsel) stbsel_q <= i_wdata[NSTB*SSW-1:0];
      end
   end

   // Swap request: a new request in the sync cycle survives the clear
   generate
      for (genvar l = 0; l < NLINK; l++) begin : g_swap
         assign act_d[l] = act_q[l] ^ (swap_q[l] && cfg_q[CFG_SHADOW]
                                       && sdet_w[2*l] && lon_w[2*l]);
         always_ff @(posedge i_clock or negedge rstn) begin
            if (!rstn) begin
               swap_q[l] <= 1'b0;
               act_q[l]  <= 1'b0;
            end else begin
               act_q[l]  <= act_d[l];
               swap_q[l] <= (wr_chen && i_wdata[CHEN_SWAP+l])
                            || (swap_q[l] && !(act_d[l] != act_q[l]));
            end
         end
      end
   endgenerate

   // Partition size: two links and shadowing each halve it
   assign sh_w  = {1'b0, cfg_q[CFG_TWO]} + {1'b0, cfg_q[CFG_SHADOW]};
   assign pm1_w = IDX_MAX >> sh_w;

   // Slot assigner engines, one per link and direction
   generate
      for (genvar e = 0; e < NENG; e++) begin : g_eng
         localparam int L  = e / 2;
         localparam bit TX = (e % 2) == 1;
         logic              ck, sy, bit_end, ent_end;
         logic [CNTW-1:0]   lim;
         logic [CSW-1:0]    csel;
         logic [IW-1:0]     loff, last;
         assign ck = pin_q[(TX ? PIN_TCLK : PIN_RCLK) + L];
         assign sy = pin_q[(TX ? PIN_TSYNC : PIN_RSYNC) + L];
         assign edge_w[e] = cfg_q[CFG_FE+L] ? (ckp_q[e] && !ck) : (!ckp_q[e] && ck);
         assign tick_w[e] = edge_w[e] && (!cfg_q[CFG_X2+L] || ph_q[e]);
         assign sdet_w[e] = edge_w[e] && sy && !syp_q[e];
         assign lon_w[e]  = cfg_q[CFG_EN+L] && (L == 0 || cfg_q[CFG_TWO]);
         assign ent_w[e]  = TX ? txram[idx_q[e]] : rxram[idx_q[e]];
         assign loff      = (L == 1) ? LINK_OFF : '0;
         assign base_w[e] = loff + ((cfg_q[CFG_SHADOW] && act_q[L]) ? pm1_w + 1'b1 : '0);
         assign base_n[e] = loff + ((cfg_q[CFG_SHADOW] && act_d[L]) ? pm1_w + 1'b1 : '0);
         assign last      = base_w[e] + pm1_w;
         // Byte entries run (n+1)*8 bits, bit entries n+1 bits
         assign lim = ent_w[e][E_BYT] ? {ent_w[e][E_CNT +: CKW], 3'h7}
                                      : {3'h0, ent_w[e][E_CNT +: CKW]};
         assign bit_end = (cnt_q[e] == lim);
         assign ent_end = bit_end && (ent_w[e][E_LST] || idx_q[e] == last)
                          || (fb_q[e] == FRAME_LAST);
         assign csel = ent_w[e][E_CSEL +: CSW];
         assign run_w[e] = (st_q[e] == ST_RUN);
         // Only channels switched to the slot assigner receive hits; protocol is not seen
         assign hit_w[e] = (run_w[e] && tick_w[e] && csel != '0 && csel <= CSW'(NCH))
                           ? ((NCH'(1) << (csel - CSW'(1))) & chen_q) : '0;
         assign rb_w[e] = (cfg_q[CFG_LOOP+L] || ent_w[e][E_LOOP])
                          ? o_tdm_txd[L] : pin_q[PIN_RXD+L];

         // Edge tracking and 2x phase
         always_ff @(posedge i_clock or negedge rstn) begin
            if (!rstn) begin
               ckp_q[e] <= 1'b0;
               syp_q[e] <= 1'b0;
               ph_q[e]  <= 1'b0;
            end else begin
               ckp_q[e] <= ck;
               if (edge_w[e]) syp_q[e] <= sy;
               if (edge_w[e]) ph_q[e] <= sdet_w[e] ? 1'b0 : !ph_q[e];
            end
         end

         // Frame sequencer
         always_ff @(posedge i_clock or negedge rstn) begin
            if (!rstn) begin
               st_q[e]  <= ST_IDLE;
               idx_q[e] <= '0;
               cnt_q[e] <= '0;
               fb_q[e]  <= '0;
               dly_q[e] <= '0;
               stb_q[e] <= '0;
            end else if (!lon_w[e]) begin
               st_q[e]  <= ST_IDLE;
               stb_q[e] <= '0;
            end else if (sdet_w[e]) begin
               st_q[e]  <= (cfg_q[CFG_DLY+2*L +: 2] == '0) ? ST_RUN : ST_DELAY;
               dly_q[e] <= cfg_q[CFG_DLY+2*L +: 2];
               idx_q[e] <= base_n[e];
               cnt_q[e] <= '0;
               fb_q[e]  <= '0;
            end else if (tick_w[e]) begin
               unique case (st_q[e])
                  ST_IDLE: begin
                     stb_q[e] <= '0;
                  end
                  ST_DELAY: begin
                     dly_q[e] <= dly_q[e] - DLY_ONE;
                     if (dly_q[e] == DLY_ONE) st_q[e] <= ST_RUN;
                  end
                  ST_RUN: begin
                     stb_q[e] <= ent_w[e][E_STB +: NSTB];
                     fb_q[e]  <= fb_q[e] + 1'b1;
                     cnt_q[e] <= bit_end ? '0 : cnt_q[e] + 1'b1;
                     if (bit_end) idx_q[e] <= idx_q[e] + 1'b1;
                     if (ent_end) st_q[e] <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   // Link outputs; tx engine of link l is engine 2l+1
   generate
      for (genvar l = 0; l < NLINK; l++) begin : g_link
         always_ff @(posedge i_clock or negedge rstn) begin
            if (!rstn) begin
               o_tdm_txd[l]    <= 1'b0;
               o_tdm_txd_oe[l] <= 1'b0;
               o_tdm_clk2x[l]  <= 1'b0;
            end else begin
               o_tdm_clk2x[l] <= pin_q[PIN_RCLK+l];
               if (cfg_q[CFG_ECHO+l]) begin
                  o_tdm_txd[l]    <= pin_q[PIN_RXD+l];
                  o_tdm_txd_oe[l] <= 1'b1;
               end else if (!lon_w[2*l+1]) begin
                  o_tdm_txd_oe[l] <= 1'b0;
               end else if (tick_w[2*l+1]) begin
                  o_tdm_txd_oe[l] <= |hit_w[2*l+1];
                  if (|hit_w[2*l+1]) o_tdm_txd[l] <= |(hit_w[2*l+1] & i_ch_txd);
               end
            end
         end
      end
   endgenerate

   // Channel side: slot assigner hits or dedicated pins with selected clock
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         logic [CKW-1:0] cs;
         logic           ckl, ckp_c;
         assign cs  = cksel_q[c*CKW +: CKW];
         // Upper code half picks a baud generator, lower half an external pin
         assign ckl = cs[CKW-1] ? i_baud_gen[cs[1:0]] : pin_q[PIN_EXTCK + cs[2:0]];
         always_ff @(posedge i_clock or negedge rstn) begin
            if (!rstn) begin
               ckp_c          <= 1'b0;
               o_ch_clk[c]    <= 1'b0;
               o_ch_rx_stb[c] <= 1'b0;
               o_ch_rx_bit[c] <= 1'b0;
               o_ch_tx_stb[c] <= 1'b0;
               o_dp_txd[c]    <= 1'b0;
            end else begin
               ckp_c       <= ckl;
               o_ch_clk[c] <= ckl;
               if (chen_q[c]) begin
                  // Rx and tx hits may come from different links
                  o_ch_rx_stb[c] <= hit_w[0][c] | hit_w[2][c];
                  o_ch_rx_bit[c] <= hit_w[0][c] ? rb_w[0] : rb_w[2];
                  o_ch_tx_stb[c] <= hit_w[1][c] | hit_w[3][c];
               end else begin
                  o_ch_rx_stb[c] <= ckl && !ckp_c;
                  o_ch_rx_bit[c] <= pin_q[PIN_DPRXD+c];
                  o_ch_tx_stb[c] <= !ckl && ckp_c;
                  if (!ckl && ckp_c) o_dp_txd[c] <= i_ch_txd[c];
               end
            end
         end
      end
   endgenerate

   // Strobes pick an engine each, free of channel routing
   generate
      for (genvar s = 0; s < NSTB; s++) begin : g_stb
         always_ff @(posedge i_clock or negedge rstn) begin
            if (!rstn) o_strobe[s] <= 1'b0;
            else o_strobe[s] <= stb_q[stbsel_q[s*SSW +: SSW]][s];
         end
      end
   endgenerate

   // Read mux; data valid only in the cycle after the strobe
   assign rd_d = (i_addr[AW-1 -: 2] == RAM_SEL_TX) ? txram[i_addr[IW-1:0]]
               : (i_addr[AW-1 -: 2] == RAM_SEL_RX) ? rxram[i_addr[IW-1:0]]
               : (i_addr == OFF_CFG)      ? cfg_q
               : (i_addr == OFF_CHEN)     ? DW'({swap_q, {CHEN_SWAP-NCH{1'b0}}, chen_q})
               : (i_addr == OFF_CKSEL)    ? cksel_q[CKSEL_LO_W-1:0]
               : (i_addr == OFF_CKSEL_HI) ? DW'(cksel_q[NCH*CKW-1:CKSEL_LO_W])
               : (i_addr == OFF_STBSEL)   ? DW'(stbsel_q)
               : (i_addr == OFF_STAT)     ? DW'({run_w[3], run_w[2], run_w[1], run_w[0],
                                                 swap_q, act_q})
               : '0;
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) o_rdata <= '0;
      else o_rdata <= i_rd_stb ? rd_d : '0;
   end

   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!rstn);

   a_link_off_idle: assert property (!lon_w[0] |=> st_q[0] == ST_IDLE)
      else $error("disabled link engine not idle");
   a_swap_at_sync: assert property (swap_q[0] && cfg_q[CFG_SHADOW] && sdet_w[0] && lon_w[0]
      |=> act_q[0] != $past(act_q[0]) && !swap_q[0] || $past(wr_chen))
      else $error("shadow swap missed frame sync");
   a_swap_only_sync: assert property (!sdet_w[0] |=> $stable(act_q[0]))
      else $error("partition changed without sync");
   a_start_first: assert property (sdet_w[1] && lon_w[1] && !wr_cfg
      |=> idx_q[1] == base_w[1] && cnt_q[1] == '0 && fb_q[1] == '0)
      else $error("frame did not start at first entry");
   a_delay_zero: assert property (sdet_w[0] && lon_w[0] && cfg_q[CFG_DLY +: 2] == '0
      |=> st_q[0] == ST_RUN)
      else $error("zero delay did not start frame");
   a_delay_wait: assert property (sdet_w[0] && lon_w[0] && cfg_q[CFG_DLY +: 2] != '0
      |=> st_q[0] == ST_DELAY && dly_q[0] == $past(cfg_q[CFG_DLY +: 2]))
      else $error("nonzero delay not applied");
   a_echo_path: assert property (cfg_q[CFG_ECHO]
      |=> o_tdm_txd[0] == $past(pin_q[PIN_RXD]) && o_tdm_txd_oe[0])
      else $error("echo not returning received data");
   a_tx_quiet: assert property (!cfg_q[CFG_ECHO] && !lon_w[1] |=> !o_tdm_txd_oe[0])
      else $error("disabled link drives data");
   a_frame_bound: assert property (run_w[0] |-> idx_q[0] >= base_w[0]
      && idx_q[0] <= base_w[0] + pm1_w || $past(wr_cfg))
      else $error("entry index outside partition");
   a_strobe_clear: assert property (st_q[1] == ST_IDLE && tick_w[1] && lon_w[1]
      && !sdet_w[1] |=> stb_q[1] == '0)
      else $error("strobe held after frame end");

   c_frame_run: cover property (run_w[0] && tick_w[0] && hit_w[0] != '0);
   c_swap_done: cover property (act_q[0] != $past(act_q[0]));
   c_delay_used: cover property (st_q[0] == ST_DELAY ##1 st_q[0] == ST_RUN);
   c_echo_on: cover property (cfg_q[CFG_ECHO] && o_tdm_txd[0]);
endmodule
`default_nettype wire

// *** logic/tsr_pkg.sv ***
// Constants, register map and types for the TDM time slot router
package tsr_pkg;
   // Structure sizes
   localparam int NLINK = 2;
   localparam int NENG  = 4;
   localparam int NCH   = 6;
   localparam int NSTB  = 4;
   localparam int NEXT  = 8;
   localparam int NBAUD = 4;
   localparam int AW    = 8;
   localparam int DW    = 16;
   localparam int IW    = 6;
   localparam int RAMN  = 64;
   localparam int CNTW  = 7;
   localparam int FW    = 13;
   localparam int CSW   = 3;
   localparam int CKW   = 4;
   localparam int SSW   = 2;
   localparam int NPIN  = 24;

   // Register offsets (word addresses on the register port)
   localparam logic [1:0]    RAM_SEL_TX   = 2'h0;
   localparam logic [1:0]    RAM_SEL_RX   = 2'h1;
   localparam logic [AW-1:0] OFF_CFG      = 8'h80;
   localparam logic [AW-1:0] OFF_CHEN     = 8'h81;
   localparam logic [AW-1:0] OFF_CKSEL    = 8'h82;
   localparam logic [AW-1:0] OFF_CKSEL_HI = 8'h83;
   localparam logic [AW-1:0] OFF_STAT     = 8'h84;
   localparam logic [AW-1:0] OFF_STBSEL   = 8'h85;

   // Register fields and widths (configuration fields one bit or pair per link, except the shared CFG_TWO and CFG_SHADOW bits)
   localparam int CFG_EN     = 0;
   localparam int CFG_TWO    = 2;
   localparam int CFG_SHADOW = 3;
   localparam int CFG_FE     = 4;
   localparam int CFG_X2     = 6;
   localparam int CFG_DLY    = 8;
   localparam int CFG_ECHO   = 12;
   localparam int CFG_LOOP   = 14;
   localparam int CHEN_SWAP  = 8;
   localparam int CKSEL_LO_W = 16;
   localparam int STAT_RUN   = 4;

   // Routing entry fields
   localparam int E_LOOP = 15;
   localparam int E_STB  = 10;
   localparam int E_CSEL = 7;
   localparam int E_CNT  = 3;
   localparam int E_BYT  = 2;
   localparam int E_LST  = 1;

   // Pin vector positions after synchronisation
   localparam int PIN_RCLK  = 0;
   localparam int PIN_RSYNC = 2;
   localparam int PIN_TCLK  = 4;
   localparam int PIN_TSYNC = 6;
   localparam int PIN_RXD   = 8;
   localparam int PIN_EXTCK = 10;
   localparam int PIN_DPRXD = 18;

   // Reset values and limits
   localparam logic [DW-1:0]   REG_RST    = 16'h0000;
   localparam logic [IW-1:0]   IDX_MAX    = 6'h3F;
   localparam logic [IW-1:0]   LINK_OFF   = 6'h20;
   localparam logic [FW-1:0]   FRAME_LAST = 13'h1FFF;
   localparam logic [1:0]      DLY_ONE    = 2'h1;

   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} tsr_state_e;
endpackage

// *** testbench/tsr_link_model.sv ***
// Behavioural TDM framer that drives one link's clock, frame sync and data
`timescale 1ns/1ns
`default_nettype none
module tsr_link_model (
   // Link pins toward the router
   output logic o_clk,
   output logic o_sync,
   output logic o_dat
);
   // 320 ns period keeps the link well under the sync clock over 2.5
   localparam int HALF = 160;
   logic lvl;
   logic fe_q;

   // Clock stands at its idle level between frames, inverted for falling edge
   assign o_clk = lvl ^ fe_q;

   initial begin
      lvl = 1'b0;
      fe_q = 1'b0;
      o_sync = 1'b0;
      o_dat = 1'b0;
   end

   // Picked while idle so the level flip is an inactive edge
   task automatic set_edge(input logic fe);
      fe_q = fe;
   endtask

   // Sync and data move on the inactive edge, active edge half a period later
   task automatic period(input logic s, input logic d);
      lvl = 1'b0;
      o_sync = s;
      o_dat = d;
      #HALF lvl = 1'b1;
      #HALF;
   endtask

   // Lead-in, sync pulse, nj filler bits of 1, then eight bits MSB first
   task automatic frame(input logic x2, input int nj, input logic [7:0] data);
      period(1'b0, 1'b0);
      period(1'b1, 1'b0); // One sync per frame, raised at an inactive edge for the next active edge
      for (int b = 0; b < nj + 8; b++) begin
         repeat (x2 ? 2 : 1) period(1'b0, (b < nj) ? 1'b1 : data[7 - (b - nj)]);
      end
      period(1'b0, ~o_dat);
      lvl = 1'b0;
      o_dat = ~o_dat; // Released line goes back to the last data bit
   endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the TDM time slot router
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import tsr_pkg::*;
   logic            i_clock;
   logic            i_resetn;
   logic [AW-1:0]   i_addr;
   logic [DW-1:0]   i_wdata;
   logic            i_wr_stb;
   logic            i_rd_stb;
   logic [DW-1:0]   o_rdata;
   logic [NCH-1:0]  i_ch_txd;
   logic [NLINK-1:0] oe;
   logic [NLINK-1:0] ck2;
   logic [NSTB-1:0] stb;
   logic [NLINK-1:0] txd;
   logic [NCH-1:0]  dtx;
   logic [15:0]     ecap;
   logic [NCH-1:0]  rstb;
   logic [NCH-1:0]  rbit;
   logic            lclk;
   logic            lsync;
   logic            ldat;
   logic            ck2_q;
   logic [7:0]      cap;
   int              ncap;
   int              nstb;
   int              noe;
   int              nck;
   int              err_count;
   int              comparisons;
   // Single bit entry: strobe 0, channel 0, eight bits, last in frame
   localparam logic [DW-1:0] ENT = (16'h1 << E_STB) | (16'h1 << E_CSEL) | (16'h7 << E_CNT)
                                   | (16'h1 << E_LST);

   tsr_link_model link (.o_clk(lclk), .o_sync(lsync), .o_dat(ldat));

   tsr_top uut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata),
      .i_tdm_rclk({1'b0, lclk}), .i_tdm_rsync({1'b0, lsync}), .i_tdm_rxd({1'b0, ldat}),
      .i_tdm_tclk({1'b0, lclk}), .i_tdm_tsync({1'b0, lsync}), .o_tdm_txd(txd),
      .o_tdm_txd_oe(oe), .o_tdm_clk2x(ck2), .o_strobe(stb), .i_ext_clk({7'h00, lclk}),
      .i_baud_gen(4'h0), .i_dp_rxd({5'h00, ldat}), .o_dp_txd(dtx), .i_ch_txd(i_ch_txd),
      .o_ch_rx_stb(rstb), .o_ch_rx_bit(rbit), .o_ch_tx_stb(), .o_ch_clk()
   );

   // Clock generator, 40 ns period
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   // Gather channel 0 deliveries and pin activity for the running frame
   always @(posedge i_clock) begin
      if (rstb[0] === 1'b1) begin
         cap <= {cap[6:0], rbit[0]};
         ncap <= ncap + 1;
      end
      if (stb[0] === 1'b1) nstb <= nstb + 1;
      if (oe[0] === 1'b1) noe <= noe + 1;
      if (ck2[0] === 1'b1 && ck2_q === 1'b0) begin
         nck <= nck + 1;
         ecap <= {ecap[14:0], txd[0]};
      end
      ck2_q <= ck2[0];
   end

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr_stb <= 1'b1;
      @(posedge i_clock);
      i_wr_stb <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_rd_stb <= 1'b1;
      @(posedge i_clock);
      i_rd_stb <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic chk16(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkn(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Configure, clear the tallies away from the edge, then play one frame
   task automatic run_frame(input logic [DW-1:0] cfg, input logic fe, input logic x2,
                            input int d, input logic [7:0] data);
      link.set_edge(fe);
      wr(OFF_CFG, cfg);
      // An idle-level flip from set_edge must clear the synchroniser before the tally reset
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
      ncap = 0;
      nstb = 0;
      noe = 0;
      nck = 0;
      link.frame(x2, d, data);
      repeat (20) @(posedge i_clock);
   endtask

   task automatic test_regs;
      logic [DW-1:0] v;
      rd(OFF_CFG, v);
      chk16(v, REG_RST);
      wr(8'h40, 16'hBEEF);
      wr(8'h3F, 16'h1234);
      rd(8'h40, v);
      chk16(v, 16'hBEEF);
      rd(8'h3F, v);
      chk16(v, 16'h1234);
      wr(OFF_STAT, 16'hFFFF);
      rd(OFF_STAT, v);
      chk16(v, REG_RST);
      rd(8'h90, v);
      chk16(v, 16'h0000);
      $display("test regs done");
   endtask

   // Every edge choice, clock ratio and frame delay, RAMs filled first
   task automatic test_modes;
      wr(8'h40, ENT);
      wr(8'h00, ENT);
      wr(OFF_CHEN, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         run_frame((16'h1 << CFG_EN) | (16'(i / 4) << CFG_FE) | (16'(i % 2) << CFG_X2)
                   | (16'(i % 4) << CFG_DLY), 1'(i / 4), 1'(i % 2), i % 4, 8'h5A ^ 8'(i));
         chkn(ncap, 8);
         chk16({8'h00, cap}, {8'h00, 8'h5A ^ 8'(i)});
         chkn(nck, 3 + (i % 4 + 8) * (i % 2 + 1));
         chkn(int'(nstb > 0), 1);
      end
      $display("test modes done");
   endtask

   task automatic test_off;
      run_frame(16'h0000, 1'b0, 1'b0, 0, 8'h3C);
      chkn(ncap, 0);
      chkn(noe, 0);
      $display("test off done");
   endtask

   // Channel sends ones, line sends zeros: loopback must deliver the ones
   task automatic test_loop;
      @(posedge i_clock);
      i_ch_txd <= 6'h01;
      run_frame((16'h1 << CFG_EN) | (16'h1 << CFG_LOOP), 1'b0, 1'b0, 0, 8'h00);
      chkn(int'(noe > 0), 1);
      chkn(int'($countones(cap) >= 7), 1);
      $display("test loop done");
   endtask

   // Echo returns the received line on the transmit pin, link itself left off
   task automatic test_echo;
      run_frame(16'h1 << CFG_ECHO, 1'b0, 1'b0, 0, 8'hA5);
      chkn(int'(noe > 0), 1);
      chk16({8'h00, ecap[8:1]}, 16'h00A5);
      $display("test echo done");
   endtask

   // Channel 0 on its own pins, clocked from external pin 0 (select code 0)
   task automatic test_pins;
      wr(OFF_CHEN, 16'h0000);
      // The 320 ns link clock doubles as pin clock, far below sync clock/2
      run_frame(16'h0000, 1'b0, 1'b0, 0, 8'h96);
      chkn(ncap, 11);
      chk16({8'h00, cap}, 16'h002D);
      chkn(int'(dtx[0]), 1);
      $display("test pins done");
   endtask

   // Shadow half holds a four-bit entry; the swap at sync must select it
   task automatic test_swap;
      logic [DW-1:0] v;
      wr(8'h60, ENT ^ (16'h4 << E_CNT));
      wr(8'h20, ENT);
      wr(OFF_CHEN, 16'h0101);
      run_frame((16'h1 << CFG_EN) | (16'h1 << CFG_SHADOW), 1'b0, 1'b0, 0, 8'hC3);
      chkn(ncap, 4);
      chk16({12'h000, cap[3:0]}, 16'h000C);
      rd(OFF_STAT, v);
      chk16(v, 16'h0001);
      $display("test swap done");
   endtask

   task automatic complete_run;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Main sequence: reset for four cycles, then the scenarios
   initial begin
      i_resetn = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      i_wr_stb = 1'b0;
      i_rd_stb = 1'b0;
      i_ch_txd = '0;
      ck2_q = 1'b0;
      err_count = 0;
      comparisons = 0;
      repeat (4) @(posedge i_clock);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clock);
      test_regs;
      test_modes;
      test_off;
      test_loop;
      test_echo;
      test_pins;
      test_swap;
      complete_run;
   end

   // Watchdog well past the expected run of some 80 us
   initial begin
      #1000000;
      err_count++;
      complete_run;
   end
endmodule
`default_nettype wire
